// [rtl/gfd_divider.sv]
// Gated frequency divider counter with AXI4-Lite registers.
// Assumes src_pin and gate_pin are asynchronous and slower than aclk/2.
`timescale 1ns/100ps
`default_nettype none
module gfd_divider #(
    parameter int unsigned CNT_W = 24,
    parameter int unsigned AXI_AW = 8,
    parameter int unsigned TB_1K_HALF = gfd_pkg::TB_1K_HALF,
    parameter int unsigned TB_100_HALF = gfd_pkg::TB_100_HALF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic src_pin,
    input wire logic gate_pin,
    output logic count_out,
    output logic irq,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import gfd_pkg::*;

    localparam int unsigned HALVES [TB_NUM] = '{TB_1M_HALF, TB_100K_HALF,
        TB_10K_HALF, TB_1K_HALF, TB_100_HALF};
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    logic src_s1, src_s2, gate_s1, gate_s2;
    logic [TB_NUM-1:0] tb_wave;
    logic sig, ev, gate_ok, tc, inactive, is_pulse, cmd;
    logic run_cmd, halt_cmd, wr_go, rd_go, rd_count;
    logic [CNT_W-1:0] ratio_eff;
    gfd_clk_t clk_sel;
    gfd_gate_t gate_sel;
    gfd_style_t style;
    gfd_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic out_q, out_d, pulse_q, pulse_d, sig_q, gate_q, start_ev;
    logic [31:0] cfg_q, cfg_d, ratio_q, ratio_d, rdata_d;
    logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
    logic rolled_q, rolled_d, irq_q, irq_d;
    logic awready_q, awready_d, bvalid_q, bvalid_d, arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q;

    // Pins pass two flops; gate is driven by the host in gated modes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {src_s1, src_s2, gate_s1, gate_s2} <= 4'h0;
        end else begin
            src_s1 <= src_pin;
            src_s2 <= src_s1;
            gate_s1 <= gate_pin;
            gate_s2 <= gate_s1;
        end
    end

    // One square wave per timebase rate
    for (genvar i = 0; i < TB_NUM; i++) begin : g_tb
        gfd_timebase #(
            .HALF(HALVES[i])
        ) u_tb (
            .aclk(aclk),
            .aresetn(aresetn),
            .wave(tb_wave[i])
        );
    end

    assign clk_sel = gfd_clk_t'(cfg_q[CFG_CLK_LSB +: 3]);
    assign gate_sel = gfd_gate_t'(cfg_q[CFG_GATE_LSB +: 3]);
    assign style = gfd_style_t'(cfg_q[CFG_STYLE_LSB +: 2]);
    assign inactive = (style == STY_LOW_PULSE) || (style == STY_LOW_TOGGLE);
    assign is_pulse = (style == STY_HIGH_PULSE) || (style == STY_LOW_PULSE);
    // Ratio of zero would reach terminal count on each edge like one, so treat it as one
    assign ratio_eff = (ratio_q[CNT_W-1:0] == '0) ? ONE : ratio_q[CNT_W-1:0];

    // Counting signal mux
    always_comb begin
        unique case (clk_sel)
            CLK_PIN: sig = src_s2;
            CLK_1M: sig = tb_wave[0];
            CLK_100K, CLK_100K_B: sig = tb_wave[1];
            CLK_10K: sig = tb_wave[2];
            CLK_1K: sig = tb_wave[3];
            CLK_100: sig = tb_wave[4];
            CLK_20M: sig = 1'b0;
        endcase
    end

    // Edge select; 20 MHz exceeds aclk, so it counts every aclk cycle
    always_comb begin
        if (clk_sel == CLK_20M) begin
            ev = 1'b1;
        end else if (cfg_q[CFG_EDGE_BIT]) begin
            ev = sig_q && !sig;
        end else begin
            ev = !sig_q && sig;
        end
    end

    // Gate qualification for level modes
    always_comb begin
        unique case (gate_sel)
            GATE_HIGH: gate_ok = gate_s2;
            GATE_LOW: gate_ok = !gate_s2;
            default: gate_ok = 1'b1;
        endcase
        start_ev = (gate_sel == GATE_FALL) ? (gate_q && !gate_s2)
                                           : (!gate_q && gate_s2);
    end

    assign tc = (st_q == ST_COUNT) && ev && gate_ok && (cnt_q <= ONE);
    assign cmd = run_cmd || halt_cmd;

    // Counter core next state
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        out_d = out_q;
        pulse_d = pulse_q;
        if (halt_cmd) begin
            st_d = ST_IDLE;
            pulse_d = 1'b0;
        end else if (run_cmd) begin
            cnt_d = ratio_eff;
            out_d = inactive;
            pulse_d = 1'b0;
            if (gate_sel == GATE_RISE || gate_sel == GATE_FALL) begin
                st_d = ST_ARMED;
            end else begin
                st_d = ST_COUNT;
            end
        end else begin
            unique case (st_q)
                ST_IDLE: st_d = ST_IDLE;
                ST_ARMED: begin
                    if (start_ev) begin
                        st_d = ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    // Strobe lasts exactly one counting period
                    if (ev && pulse_q) begin
                        out_d = inactive;
                        pulse_d = 1'b0;
                    end
                    if (tc) begin
                        cnt_d = ratio_eff;
                        if (is_pulse) begin
                            out_d = !inactive;
                            pulse_d = 1'b1;
                        end else begin
                            out_d = !out_q;
                        end
                    end else if (ev && gate_ok) begin
                        cnt_d = cnt_q - ONE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            out_q <= 1'b0;
            pulse_q <= 1'b0;
            sig_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            pulse_q <= pulse_d;
            sig_q <= sig;
            gate_q <= gate_s2;
        end
    end

    // Byte lane merge for writable registers
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Write taken on the cycle awready is high; both channels arrive together
    assign wr_go = awready_q && s_axi_awvalid && s_axi_wvalid;
    assign rd_go = arready_q && s_axi_arvalid;
    assign rd_count = rd_go && (s_axi_araddr == OFF_COUNT);
    assign run_cmd = wr_go && (s_axi_awaddr == OFF_CTRL) && s_axi_wstrb[0]
                     && s_axi_wdata[CTRL_RUN_BIT];
    assign halt_cmd = wr_go && (s_axi_awaddr == OFF_CTRL) && s_axi_wstrb[0]
                      && s_axi_wdata[CTRL_HALT_BIT];

    // Register file, bus handshakes and interrupt next state
    always_comb begin
        cfg_d = cfg_q;
        ratio_d = ratio_q;
        imask_d = imask_q;
        awready_d = !awready_q && !bvalid_q && s_axi_awvalid && s_axi_wvalid;
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d = bresp_q;
        arready_d = !arready_q && !rvalid_q && s_axi_arvalid;
        rvalid_d = rvalid_q && !s_axi_rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        ist_d = ist_q;
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            unique case (s_axi_awaddr)
                OFF_CTRL, OFF_COUNT, OFF_STATUS: ;
                OFF_CONFIG: cfg_d = merge(cfg_q, s_axi_wdata, s_axi_wstrb);
                OFF_RATIO: ratio_d = merge(ratio_q, s_axi_wdata, s_axi_wstrb);
                OFF_IRQ_STAT: if (s_axi_wstrb[0]) begin
                    ist_d = ist_q & ~s_axi_wdata[IRQ_W-1:0];
                end
                OFF_IRQ_MASK: if (s_axi_wstrb[0]) begin
                    imask_d = s_axi_wdata[IRQ_W-1:0];
                end
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        // Events set after the clear so a same-cycle event survives
        ist_d[IRQ_TC_BIT] = ist_d[IRQ_TC_BIT] | tc;
        ist_d[IRQ_START_BIT] = ist_d[IRQ_START_BIT] |
                               ((st_q == ST_ARMED) && st_d == ST_COUNT);
        // Read of COUNT samples it; roll flag set wins over clear
        rolled_d = (rolled_q && !rd_count) || tc;
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = '0;
            unique case (s_axi_araddr)
                OFF_CTRL: ;
                OFF_CONFIG: rdata_d = cfg_q;
                OFF_RATIO: rdata_d[CNT_W-1:0] = ratio_q[CNT_W-1:0];
                OFF_COUNT: begin
                    rdata_d[CNT_W-1:0] = cnt_q;
                    rdata_d[CNT_ROLL_BIT] = rolled_q;
                end
                OFF_STATUS: begin
                    rdata_d[1:0] = st_q;
                    rdata_d[STAT_OUT_BIT] = out_q;
                    rdata_d[STAT_ROLL_BIT] = rolled_q;
                end
                OFF_IRQ_STAT: rdata_d[IRQ_W-1:0] = ist_q;
                OFF_IRQ_MASK: rdata_d[IRQ_W-1:0] = imask_q;
                default: rresp_d = RESP_SLVERR;
            endcase
        end
        irq_d = |(ist_d & imask_d);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= CFG_RST;
            ratio_q <= RATIO_RST;
            ist_q <= IRQ_RST;
            imask_q <= IRQ_RST;
            rolled_q <= 1'b0;
            irq_q <= 1'b0;
            awready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            ratio_q <= ratio_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            rolled_q <= rolled_d;
            irq_q <= irq_d;
            awready_q <= awready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign count_out = out_q;
    assign irq = irq_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = awready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Checks on the counter core
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_strobe_tc;
        tc && is_pulse && !cmd;
    endsequence
    sequence s_next_ev;
        ev && !tc && !cmd && st_q == ST_COUNT;
    endsequence

    property p_edge_only;
        st_q == ST_COUNT && !ev && !cmd |=> $stable(cnt_q);
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("count moved without a counting edge");
    property p_strobe_end;
        s_strobe_tc ##1 s_next_ev |=> out_q == inactive;
    endproperty
    a_strobe_end: assert property (p_strobe_end)
        else $error("strobe longer than one counting period");
    property p_toggle;
        tc && !is_pulse && !cmd |=> out_q != $past(out_q);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle style did not change level");
    property p_high_strobe;
        tc && style == STY_HIGH_PULSE && !cmd |=> out_q && pulse_q;
    endproperty
    a_high_strobe: assert property (p_high_strobe)
        else $error("raised strobe missing");
    property p_low_strobe;
        tc && style == STY_LOW_PULSE && !cmd |=> !out_q && pulse_q;
    endproperty
    a_low_strobe: assert property (p_low_strobe)
        else $error("lowered strobe missing");
    property p_free_run;
        run_cmd && !halt_cmd && gate_sel == GATE_FREE |=> st_q == ST_COUNT;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("free run did not start at once");
    property p_level_gate;
        st_q == ST_COUNT && !gate_ok && !cmd |=> $stable(cnt_q);
    endproperty
    a_level_gate: assert property (p_level_gate)
        else $error("counted while gate closed");
    property p_armed;
        st_q == ST_ARMED && !start_ev && !cmd |=> st_q == ST_ARMED;
    endproperty
    a_armed: assert property (p_armed)
        else $error("left armed state without gate edge");
    property p_halt;
        halt_cmd |=> st_q == ST_IDLE ##1 $stable(cnt_q);
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt did not stop counting");
    property p_roll;
        tc |=> rolled_q;
    endproperty
    a_roll: assert property (p_roll)
        else $error("roll flag not set at terminal count");
    property p_sample;
        rd_count |=> rvalid_q && rdata_q[CNT_W-1:0] == $past(cnt_q);
    endproperty
    a_sample: assert property (p_sample)
        else $error("count read returned wrong value");
    property p_reload;
        tc && !cmd |=> cnt_q == $past(ratio_eff) && st_q == ST_COUNT;
    endproperty
    a_reload: assert property (p_reload)
        else $error("ratio not reloaded at terminal count");
    property p_rest;
        run_cmd && !halt_cmd |=> out_q == $past(inactive) && !pulse_q;
    endproperty
    a_rest: assert property (p_rest)
        else $error("output not at inactive level after run");
endmodule
`default_nettype wire

// [rtl/gfd_pkg.sv]
// Constants, register map and mode types for the frequency divider counter.
// Assumes a single 10 MHz aclk domain and an AXI4-Lite register bus.
package gfd_pkg;
    // Core clock and derived timebase half periods
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TB_1M_HZ = 1_000_000;
    localparam int unsigned TB_100K_HZ = 100_000;
    localparam int unsigned TB_10K_HZ = 10_000;
    localparam int unsigned TB_1K_HZ = 1_000;
    localparam int unsigned TB_100_HZ = 100;
    localparam int unsigned TB_20M_HZ = 20_000_000;
    localparam int unsigned TB_1M_HALF = CLK_HZ / (2 * TB_1M_HZ);
    localparam int unsigned TB_100K_HALF = CLK_HZ / (2 * TB_100K_HZ);
    localparam int unsigned TB_10K_HALF = CLK_HZ / (2 * TB_10K_HZ);
    localparam int unsigned TB_1K_HALF = CLK_HZ / (2 * TB_1K_HZ);
    localparam int unsigned TB_100_HALF = CLK_HZ / (2 * TB_100_HZ);
    localparam int unsigned TB_NUM = 5;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CONFIG = 8'h04;
    localparam logic [7:0] OFF_RATIO = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

    // Field positions
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_HALT_BIT = 1;
    localparam int unsigned CFG_CLK_LSB = 0;
    localparam int unsigned CFG_EDGE_BIT = 4;
    localparam int unsigned CFG_GATE_LSB = 8;
    localparam int unsigned CFG_STYLE_LSB = 12;
    localparam int unsigned STAT_OUT_BIT = 2;
    localparam int unsigned STAT_ROLL_BIT = 3;
    localparam int unsigned CNT_ROLL_BIT = 31;
    localparam int unsigned IRQ_TC_BIT = 0;
    localparam int unsigned IRQ_START_BIT = 1;
    localparam int unsigned IRQ_W = 2;

    // Reset values
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] RATIO_RST = 32'h0000_0002;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CLK_PIN, CLK_1M, CLK_100K, CLK_10K, CLK_1K, CLK_100, CLK_20M,
        CLK_100K_B
    } gfd_clk_t;
    typedef enum logic [2:0] {
        GATE_FREE, GATE_HIGH, GATE_LOW, GATE_RISE, GATE_FALL
    } gfd_gate_t;
    typedef enum logic [1:0] {
        STY_HIGH_PULSE, STY_LOW_PULSE, STY_HIGH_TOGGLE, STY_LOW_TOGGLE
    } gfd_style_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_COUNT} gfd_state_t;
endpackage

// [rtl/gfd_timebase.sv]
// Square wave timebase: toggles every HALF aclk cycles.
// Assumes HALF >= 1; runs freely from reset.
`timescale 1ns/100ps
`default_nettype none
module gfd_timebase #(
    parameter int unsigned HALF = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic wave
);
    localparam int unsigned CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic wave_q;
    logic wave_d;

    // Half period counter
    always_comb begin
        cnt_d = cnt_q + CW'(1);
        wave_d = wave_q;
        if (cnt_q == LAST) begin
            cnt_d = '0;
            wave_d = ~wave_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            wave_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            wave_q <= wave_d;
        end
    end

    assign wave = wave_q;
endmodule
`default_nettype wire

// [sim/gfd_divider_tb.sv]
// Self-checking bench for the divider, driven over AXI4-Lite.
// Assumes pin source period of 8 aclk and shortened timebase halves.
`timescale 1ns/100ps
`default_nettype none
module gfd_divider_tb;
    import gfd_pkg::*;
    logic aclk = 0, aresetn = 0, src_en = 0, src_pin, gate_pin = 0;
    logic count_out, irq, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    int n_fail = 0, tests_run = 0, n;
    always #50 aclk = ~aclk;
    gfd_src_model #(.HALF(4)) i_gfd_src_model (.aclk(aclk), .en(src_en),
        .pin(src_pin));
    gfd_divider #(.TB_1K_HALF(5), .TB_100_HALF(10)) i_gfd_divider (
        .aclk(aclk), .aresetn(aresetn), .src_pin(src_pin),
        .gate_pin(gate_pin), .count_out(count_out), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // Verdict in one place
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait on a sampled flag; a hang ends the run
    task automatic wait_hi(ref logic f);
        int k;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (f !== 1'b1 && k < 100);
        if (f !== 1'b1) begin
            n_fail++;
            complete_run();
        end
    endtask
    // Each write channel is released on its own ready
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bit aw_ok, w_ok;
        int k;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        k = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok) && k < 100) begin
            @(posedge aclk);
            k++;
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (!(aw_ok && w_ok)) begin
            n_fail++;
            complete_run();
        end
        bready <= 1'b1;
        wait_hi(bvalid);
        bready <= 1'b0;
    endtask
    task automatic rdw(logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        wait_hi(arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        wait_hi(rvalid);
        rd = rdata;
        rready <= 1'b0;
    endtask
    // Counts cycles with the output at a level over a window
    task automatic act(int cyc, logic lvl);
        n = 0;
        repeat (cyc) begin
            @(posedge aclk);
            if (count_out === lvl) n++;
        end
    endtask
    function automatic logic [31:0] cfg(int c, int g, int s);
        return 32'(c) | (32'(g) << CFG_GATE_LSB) | (32'(s) << CFG_STYLE_LSB);
    endfunction
    task automatic start(logic [31:0] c, logic [31:0] r);
        wr(OFF_CTRL, 32'h2);
        wr(OFF_CONFIG, c);
        wr(OFF_RATIO, r);
        wr(OFF_CTRL, 32'h1);
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdw(OFF_CONFIG);
        check("config reset", rd, CFG_RST);
        rdw(OFF_RATIO);
        check("ratio reset", rd, RATIO_RST);
        rdw(8'h20);
        check("unmapped resp", 32'(rresp), 32'(RESP_SLVERR));
        wr(8'h20, 32'h0);
        check("unmapped wresp", 32'(bresp), 32'(RESP_SLVERR));
        $display("test registers done");
        // Every style, pin source, ratio 3, known source phase
        for (int s = 0; s < 4; s++) begin
            start(cfg(0, 0, s), 32'h3);
            check("rest level", 32'(count_out), 32'(s % 2));
            src_en <= 1'b1;
            act(64, s % 2 == 0);
            check("active cycles", n, (s < 2) ? 16 : 24);
            src_en <= 1'b0;
        end
        $display("test styles done");
        check("irq masked", 32'(irq), 32'h0);
        wr(OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        check("irq raised", 32'(irq), 32'h1);
        wr(OFF_IRQ_STAT, 32'h3);
        repeat (2) @(posedge aclk);
        check("irq cleared", 32'(irq), 32'h0);
        rdw(OFF_COUNT);
        check("rolled set", 32'(rd[CNT_ROLL_BIT]), 32'h1);
        rdw(OFF_COUNT);
        check("rolled clr", 32'(rd[CNT_ROLL_BIT]), 32'h0);
        wr(OFF_CTRL, 32'h2);
        rdw(OFF_STATUS);
        check("halt state", 32'(rd[1:0]), 32'h0);
        rdw(OFF_COUNT);
        n = int'(rd);
        src_en <= 1'b1;
        repeat (32) @(posedge aclk);
        rdw(OFF_COUNT);
        check("count held", rd, 32'(n));
        $display("test halt done");
        // Level gate: closed gate blocks terminal counts
        gate_pin <= 1'b0;
        start(cfg(0, 1, 0), 32'h3);
        wr(OFF_IRQ_STAT, 32'h3);
        repeat (64) @(posedge aclk);
        rdw(OFF_IRQ_STAT);
        check("gate closed", 32'(rd[IRQ_TC_BIT]), 32'h0);
        gate_pin <= 1'b1;
        repeat (64) @(posedge aclk);
        rdw(OFF_IRQ_STAT);
        check("gate open", 32'(rd[IRQ_TC_BIT]), 32'h1);
        // Edge start modes wait armed until their edge
        for (int g = 3; g < 5; g++) begin
            gate_pin <= (g == 4);
            start(cfg(0, g, 0), 32'h3);
            rdw(OFF_STATUS);
            check("armed", 32'(rd[1:0]), 32'h1);
            wr(OFF_IRQ_STAT, 32'h3);
            gate_pin <= (g == 3);
            repeat (6) @(posedge aclk);
            rdw(OFF_STATUS);
            check("started", 32'(rd[1:0]), 32'h2);
            rdw(OFF_IRQ_STAT);
            check("start event", 32'(rd[IRQ_START_BIT]), 32'h1);
        end
        $display("test gating done");
        src_en <= 1'b0;
        // Internal timebases: every aclk, and 10-cycle period
        start(cfg(6, 0, 0), 32'h5);
        repeat (20) @(posedge aclk);
        act(50, 1'b1);
        check("fast timebase", n, 10);
        // The 1 MHz and shortened 1 kHz rates both run with a 10-cycle period here
        for (int c = 1; c < 5; c += 3) begin
            start(cfg(c, 0, 0), 32'h2);
            repeat (40) @(posedge aclk);
            act(100, 1'b1);
            check("slow timebase", n, 50);
        end
        // Falling edge counts: first toggle after the pin falls
        start(cfg(0, 0, 2) | (32'h1 << CFG_EDGE_BIT), 32'h1);
        src_en <= 1'b1;
        act(12, 1'b1);
        check("falling edge", n, 1);
        src_en <= 1'b0;
        $display("test timebase done");
        complete_run();
    end
endmodule
`default_nettype wire

// [sim/gfd_src_model.sv]
// Stand-in for whatever drives the counting source pin.
// Assumes the bench enables it for pin-fed tests, including while the count is halted or gated off.
`timescale 1ns/100ps
`default_nettype none
module gfd_src_model #(
    parameter int HALF = 4
) (
    input wire logic aclk,
    input wire logic en,
    output logic pin
);
    int c_q;
    // Square wave from a known phase; stands low while disabled
    always_ff @(posedge aclk) begin
        if (!en) begin
            pin <= 1'b0;
            c_q <= 0;
        end else if (c_q == HALF - 1) begin
            pin <= ~pin;
            c_q <= 0;
        end else begin
            c_q <= c_q + 1;
        end
    end
endmodule
`default_nettype wire
